// file: core/led_cfg_defs.svh
// Offsets, field positions, reset values and masks of the output channel configuration register.
`ifndef LED_CFG_DEFS_SVH
`define LED_CFG_DEFS_SVH

`define CFG_ADDR_W 2
`define CFG_DATA_W 16
`define CFG_REG_W 48
`define CFG_WORD_LO_ADDR 2'h0
`define CFG_WORD_MID_ADDR 2'h1
`define CFG_WORD_HI_ADDR 2'h2

`define CFG_RESET_VALUE 48'h0800_0540_403C
`define CFG_WRITE_MASK 48'h1FFF_0FFF_4002

`define CEILING_BIT 1
`define UPPER_SCAN_REVERSE_BIT 14
`define FINE_LSB 16
`define TURNOFF_LSB 19
`define TURNON_LSB 22
`define COARSE_LSB 32
`define DIM_LSB 35
`define ISO_EN_BIT 39
`define BOOST_LVL_LSB 40
`define BOOST_EN_BIT 44

`define SCAN_HALF_LINES 16
`define LEVEL_W 5
`define CODE_W 4

`endif

// file: core/led_cfg_pkg.sv
// Types shared by the output channel configuration logic.
package led_cfg_pkg;

  typedef enum logic [1:0] {
    TURNON_SLOWEST = 2'h0,
    TURNON_SLOW = 2'h1,
    TURNON_FAST = 2'h2,
    TURNON_FASTEST = 2'h3
  } turnon_rate_e;

  typedef enum logic {
    CEILING_10MA = 1'h0,
    CEILING_20MA = 1'h1
  } current_ceiling_e;

  typedef logic [2:0] colour_bits_t;

endpackage : led_cfg_pkg

// file: core/level_decode.sv
// Turns a four-bit level code into its level number, zero while disabled.
`timescale 1ns/1ps
`include "led_cfg_defs.svh"

module level_decode (
  input wire logic [`CODE_W-1:0] code_i,
  input wire logic enable_i,
  output logic [`LEVEL_W-1:0] level_o
);

  // Code n means level n plus one, so the sum needs one more bit.
  assign level_o = enable_i ? ({1'h0, code_i} + 5'h01) : 5'h00;

endmodule : level_decode

// file: core/scan_order_map.sv
// Maps a scan step to the scan line and memory row it addresses.
`timescale 1ns/1ps
`include "led_cfg_defs.svh"

module scan_order_map (
  input wire logic reverse_i,
  input wire logic [4:0] step_i,
  output logic [4:0] row_o
);

  // The lower sixteen lines are never reordered; the upper half may run 31 down to 16.
  assign row_o = (step_i[4] && reverse_i) ? {1'h1, ~step_i[3:0]} : step_i;

endmodule : scan_order_map

// file: core/output_channel_configuration.sv
// Output channel configuration register with its decoded controls and scan ordering.
// Functional notes
// R01: Bit 1 picks the channel current ceiling, zero for 10 mA and one for 20 mA, reset zero.
// R02: Bit 14 resets to one and, when set, makes the second sixteen scan lines run 31 down to 16.
// R03: Bits 16 to 18 enable the fine compensation range of red, green and blue, reset zero.
// R04: Bits 32 to 34 enable the coarse compensation range of red, green and blue, reset zero.
// R05: Bits 19 to 21 pick slow or fast turn-off edge rate per colour, reset slow.
// R06: Two-bit fields at 23-22, 25-24 and 27-26 pick the turn-on edge rate per colour, reset 01.
// R07: Bits 38-35 give the first-line dimming level as code plus one, reset code zero.
// R08: Bit 39 enables isolation between switching-on and switching-off channels, reset zero.
// R09: Bits 43-40 give boost level as code plus one, reset 1000, active only while bit 44 set.
// R10: Reserved bits 0, 13-2, 15, 31-28 and 47-45 read fixed reset values and ignore writes.
`timescale 1ns/1ps
`include "led_cfg_defs.svh"

module output_channel_configuration (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [`CFG_ADDR_W-1:0] reg_addr_i,
  input wire logic [`CFG_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`CFG_DATA_W-1:0] reg_rdata_o,
  input wire logic [4:0] scan_step_i,
  output logic [4:0] scan_row_o,
  output led_cfg_pkg::current_ceiling_e channel_current_ceiling_sel_o,
  output logic upper_scan_order_reverse_o,
  output led_cfg_pkg::colour_bits_t fine_range_en_o,
  output led_cfg_pkg::colour_bits_t coarse_range_en_o,
  output logic red_turnoff_edge_rate_o,
  output logic green_turnoff_edge_rate_o,
  output logic blue_turnoff_edge_rate_o,
  output led_cfg_pkg::turnon_rate_e red_turnon_edge_rate_o,
  output led_cfg_pkg::turnon_rate_e green_turnon_edge_rate_o,
  output led_cfg_pkg::turnon_rate_e blue_turnon_edge_rate_o,
  output logic [`LEVEL_W-1:0] first_line_dim_level_o,
  output logic on_off_channel_isolation_en_o,
  output logic isolation_boost_en_o,
  output logic [`LEVEL_W-1:0] isolation_boost_level_o
);

  localparam logic [`CFG_REG_W-1:0] RESET_VALUE = `CFG_RESET_VALUE;
  localparam logic [`CFG_REG_W-1:0] WRITE_MASK = `CFG_WRITE_MASK;

  logic [`CFG_REG_W-1:0] cfg;
  logic [`CFG_REG_W-1:0] next_cfg;
  logic [`CFG_REG_W-1:0] write_bits;
  logic [`CFG_REG_W-1:0] lane_mask;
  logic [`LEVEL_W-1:0] dim_level;
  logic [`LEVEL_W-1:0] boost_level;
  logic [4:0] mapped_row;

  // Decodes which sixteen-bit lane of the register a bus address selects.
  function automatic logic [`CFG_REG_W-1:0] lane_of(input logic [`CFG_ADDR_W-1:0] addr);
    logic [`CFG_REG_W-1:0] lane;
    lane = 48'h0000_0000_0000;
    unique case (addr)
      `CFG_WORD_LO_ADDR: lane = 48'h0000_0000_FFFF;
      `CFG_WORD_MID_ADDR: lane = 48'h0000_FFFF_0000;
      `CFG_WORD_HI_ADDR: lane = 48'hFFFF_0000_0000;
      default: lane = 48'h0000_0000_0000;
    endcase
    return lane;
  endfunction : lane_of

  assign lane_mask = lane_of(reg_addr_i);
  assign write_bits = {3{reg_wdata_i}};

  // R10 reserved bits fixed
  always_comb
  begin
    next_cfg = cfg;
    if (reg_wr_i)
    begin
      next_cfg = (cfg & ~lane_mask) | (write_bits & lane_mask);
    end
    // Reserved bits are forced back so no write can ever disturb them.
    next_cfg = (next_cfg & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
  end

  // R01 R02 reset values held
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg <= `CFG_RESET_VALUE;
    end
    else
    begin
      cfg <= next_cfg;
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped words read zero.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o <= 16'h0000;
    end
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `CFG_WORD_LO_ADDR: reg_rdata_o <= cfg[15:0];
        `CFG_WORD_MID_ADDR: reg_rdata_o <= cfg[31:16];
        `CFG_WORD_HI_ADDR: reg_rdata_o <= cfg[47:32];
        default: reg_rdata_o <= 16'h0000;
      endcase
    end
    else
    begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // R01 current ceiling select
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      channel_current_ceiling_sel_o <= led_cfg_pkg::CEILING_10MA;
    end
    else
    begin
      channel_current_ceiling_sel_o <= led_cfg_pkg::current_ceiling_e'(cfg[`CEILING_BIT]);
    end
  end

  // R03 R04 compensation enables
  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1)
    begin : g_colour
      always_ff @(posedge ref_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          fine_range_en_o[c] <= 1'h0;
          coarse_range_en_o[c] <= 1'h0;
        end
        else
        begin
          fine_range_en_o[c] <= cfg[`FINE_LSB + c];
          coarse_range_en_o[c] <= cfg[`COARSE_LSB + c];
        end
      end
    end
  endgenerate

  // R05 turn-off edge rates
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      red_turnoff_edge_rate_o <= 1'h0;
      green_turnoff_edge_rate_o <= 1'h0;
      blue_turnoff_edge_rate_o <= 1'h0;
    end
    else
    begin
      red_turnoff_edge_rate_o <= cfg[`TURNOFF_LSB];
      green_turnoff_edge_rate_o <= cfg[`TURNOFF_LSB + 1];
      blue_turnoff_edge_rate_o <= cfg[`TURNOFF_LSB + 2];
    end
  end

  // R06 turn-on edge rates
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      red_turnon_edge_rate_o <= led_cfg_pkg::TURNON_SLOW;
      green_turnon_edge_rate_o <= led_cfg_pkg::TURNON_SLOW;
      blue_turnon_edge_rate_o <= led_cfg_pkg::TURNON_SLOW;
    end
    else
    begin
      red_turnon_edge_rate_o <= led_cfg_pkg::turnon_rate_e'(cfg[`TURNON_LSB +: 2]);
      green_turnon_edge_rate_o <= led_cfg_pkg::turnon_rate_e'(cfg[`TURNON_LSB + 2 +: 2]);
      blue_turnon_edge_rate_o <= led_cfg_pkg::turnon_rate_e'(cfg[`TURNON_LSB + 4 +: 2]);
    end
  end

  // R07 first-line dim level
  level_decode u_dim_level (
    .code_i(cfg[`DIM_LSB +: `CODE_W]),
    .enable_i(1'h1),
    .level_o(dim_level)
  );

  // R09 boost level gated
  level_decode u_boost_level (
    .code_i(cfg[`BOOST_LVL_LSB +: `CODE_W]),
    .enable_i(cfg[`BOOST_EN_BIT]),
    .level_o(boost_level)
  );

  // R07 R08 R09 level outputs
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      first_line_dim_level_o <= 5'h01;
      on_off_channel_isolation_en_o <= 1'h0;
      isolation_boost_en_o <= 1'h0;
      isolation_boost_level_o <= 5'h00;
    end
    else
    begin
      first_line_dim_level_o <= dim_level;
      on_off_channel_isolation_en_o <= cfg[`ISO_EN_BIT];
      isolation_boost_en_o <= cfg[`BOOST_EN_BIT];
      isolation_boost_level_o <= boost_level;
    end
  end

  // R02 scan order mapping
  scan_order_map u_scan_map (
    .reverse_i(cfg[`UPPER_SCAN_REVERSE_BIT]),
    .step_i(scan_step_i),
    .row_o(mapped_row)
  );

  // R02 scan reverse output
  // Row and flag are registered together so a reordering never tears mid-line.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      upper_scan_order_reverse_o <= 1'h1;
      scan_row_o <= 5'h00;
    end
    else
    begin
      upper_scan_order_reverse_o <= cfg[`UPPER_SCAN_REVERSE_BIT];
      scan_row_o <= mapped_row;
    end
  end

  a_reserved_fixed: assert property ( // R10
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (cfg & ~WRITE_MASK) == (RESET_VALUE & ~WRITE_MASK))
    else $error("Reserved configuration bits changed.");

  a_read_low_word: assert property ( // R10
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    reg_rd_i && !reg_wr_i && reg_addr_i == `CFG_WORD_LO_ADDR
      |=> reg_rdata_o[0] == 1'h0 && reg_rdata_o[5:2] == 4'hF && reg_rdata_o[13:6] == 8'h00)
    else $error("Reserved low-word bits read wrong.");

  a_ceiling_follows: assert property ( // R01
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == `CFG_WORD_LO_ADDR
      |=> ##1 channel_current_ceiling_sel_o == $past(reg_wdata_i[1], 2))
    else $error("Current ceiling does not follow the write.");

  a_scan_reverse_map: assert property ( // R02
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    cfg[`UPPER_SCAN_REVERSE_BIT] && scan_step_i == 5'h10 |=> scan_row_o == 5'h1F)
    else $error("Reversed upper scan half mapped wrongly.");

  a_scan_forward_map: assert property ( // R02
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !cfg[`UPPER_SCAN_REVERSE_BIT] || !scan_step_i[4] |=> scan_row_o == $past(scan_step_i))
    else $error("Forward scan order altered.");

  a_fine_coarse_en: assert property ( // R03
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ##1 fine_range_en_o == $past(cfg[18:16]) && coarse_range_en_o == $past(cfg[34:32]))
    else $error("Compensation range enables mismatch.");

  a_turnoff_rates: assert property ( // R05
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == `CFG_WORD_MID_ADDR
      |=> ##1 blue_turnoff_edge_rate_o == $past(reg_wdata_i[5], 2))
    else $error("Turn-off edge rate does not follow the write.");

  a_turnon_rates: assert property ( // R06
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == `CFG_WORD_MID_ADDR
      |=> ##1 green_turnon_edge_rate_o == $past(reg_wdata_i[9:8], 2))
    else $error("Turn-on edge rate does not follow the write.");

  a_dim_plus_one: assert property ( // R07
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ##1 first_line_dim_level_o == {1'h0, $past(cfg[38:35])} + 5'h01)
    else $error("Dim level is not code plus one.");

  a_isolation_en: assert property ( // R08
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == `CFG_WORD_HI_ADDR
      |=> ##1 on_off_channel_isolation_en_o == $past(reg_wdata_i[7], 2))
    else $error("Isolation enable does not follow the write.");

  a_boost_gated: assert property ( // R09
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !isolation_boost_en_o |-> isolation_boost_level_o == 5'h00)
    else $error("Boost level shown while boost disabled.");

  a_boost_level: assert property ( // R09
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    cfg[`BOOST_EN_BIT] |=> isolation_boost_level_o == {1'h0, $past(cfg[43:40])} + 5'h01)
    else $error("Boost level is not code plus one.");

endmodule : output_channel_configuration

// file: tb/test_output_channel_configuration.sv
// Self-checking bench for the output channel configuration register.
`timescale 1ns/1ps
`include "led_cfg_defs.svh"

module test_output_channel_configuration;
  logic ref_clk_i;
  logic rst_n_i;
  logic [`CFG_ADDR_W-1:0] reg_addr_i;
  logic [`CFG_DATA_W-1:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [`CFG_DATA_W-1:0] reg_rdata_o;
  logic [4:0] scan_step_i;
  logic [4:0] scan_row_o;
  led_cfg_pkg::current_ceiling_e channel_current_ceiling_sel_o;
  logic upper_scan_order_reverse_o;
  led_cfg_pkg::colour_bits_t fine_range_en_o;
  led_cfg_pkg::colour_bits_t coarse_range_en_o;
  logic red_turnoff_edge_rate_o;
  logic green_turnoff_edge_rate_o;
  logic blue_turnoff_edge_rate_o;
  led_cfg_pkg::turnon_rate_e red_turnon_edge_rate_o;
  led_cfg_pkg::turnon_rate_e green_turnon_edge_rate_o;
  led_cfg_pkg::turnon_rate_e blue_turnon_edge_rate_o;
  logic [`LEVEL_W-1:0] first_line_dim_level_o;
  logic on_off_channel_isolation_en_o;
  logic isolation_boost_en_o;
  logic [`LEVEL_W-1:0] isolation_boost_level_o;
  int failures;
  int compares;
  logic [47:0] rows [4];
  logic [47:0] expect_rows [4];
  logic [47:0] e;
  logic [15:0] d;

  output_channel_configuration dut (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .scan_step_i(scan_step_i),
    .scan_row_o(scan_row_o),
    .channel_current_ceiling_sel_o(channel_current_ceiling_sel_o),
    .upper_scan_order_reverse_o(upper_scan_order_reverse_o),
    .fine_range_en_o(fine_range_en_o),
    .coarse_range_en_o(coarse_range_en_o),
    .red_turnoff_edge_rate_o(red_turnoff_edge_rate_o),
    .green_turnoff_edge_rate_o(green_turnoff_edge_rate_o),
    .blue_turnoff_edge_rate_o(blue_turnoff_edge_rate_o),
    .red_turnon_edge_rate_o(red_turnon_edge_rate_o),
    .green_turnon_edge_rate_o(green_turnon_edge_rate_o),
    .blue_turnon_edge_rate_o(blue_turnon_edge_rate_o),
    .first_line_dim_level_o(first_line_dim_level_o),
    .on_off_channel_isolation_en_o(on_off_channel_isolation_en_o),
    .isolation_boost_en_o(isolation_boost_en_o),
    .isolation_boost_level_o(isolation_boost_level_o)
  );

  task automatic conclude();
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'h0;
  endtask : wr

  // Read data stand only in the cycle after the read edge, so sample there.
  task automatic rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'h0;
    #1;
    v = reg_rdata_o;
  endtask : rd

  task automatic check_reg(input logic [47:0] x);
    logic [15:0] v;
    rd(`CFG_WORD_LO_ADDR, v);
    check(v, x[15:0]);
    rd(`CFG_WORD_MID_ADDR, v);
    check(v, x[31:16]);
    rd(`CFG_WORD_HI_ADDR, v);
    check(v, x[47:32]);
  endtask : check_reg

  task automatic check_outputs(input logic [47:0] x);
    logic [4:0] boost;
    boost = x[44] ? {1'h0, x[43:40]} + 5'h01 : 5'h00;
    check(channel_current_ceiling_sel_o, x[1]);
    check(upper_scan_order_reverse_o, x[14]);
    check(fine_range_en_o, x[18:16]);
    check(coarse_range_en_o, x[34:32]);
    check({blue_turnoff_edge_rate_o, green_turnoff_edge_rate_o, red_turnoff_edge_rate_o},
      x[21:19]);
    check({blue_turnon_edge_rate_o, green_turnon_edge_rate_o, red_turnon_edge_rate_o},
      x[27:22]);
    check(first_line_dim_level_o, {1'h0, x[38:35]} + 5'h01);
    check(on_off_channel_isolation_en_o, x[39]);
    check({isolation_boost_en_o, isolation_boost_level_o}, {x[44], boost});
  endtask : check_outputs

  task automatic check_scan(input logic rev);
    logic [4:0] s;
    for (int i = 0; i < 32; i++)
    begin
      s = i[4:0];
      @(posedge ref_clk_i);
      scan_step_i <= s;
      @(posedge ref_clk_i);
      #1;
      check(scan_row_o, (rev && s[4]) ? 5'h1F - (s - 5'h10) : s);
    end
  endtask : check_scan

  initial
  begin
    ref_clk_i = 1'h0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  initial
  begin : watchdog
    repeat (20000) @(posedge ref_clk_i);
    failures++;
    conclude();
  end

  initial
  begin
    rst_n_i = 1'h0;
    reg_addr_i = 2'h0;
    reg_wdata_i = 16'h0000;
    reg_wr_i = 1'h0;
    reg_rd_i = 1'h0;
    scan_step_i = 5'h00;
    rows[0] = 48'hFFFF_FFFF_FFFF;
    rows[1] = 48'h0000_0000_0000;
    rows[2] = 48'hAAAA_AAAA_AAAA;
    rows[3] = 48'h5555_5555_5555;
    // Writable bits keep what was written; reserved bits keep their fixed pattern.
    expect_rows[0] = 48'h1FFF_0FFF_403E;
    expect_rows[1] = 48'h0000_0000_003C;
    expect_rows[2] = 48'h0AAA_0AAA_003E;
    expect_rows[3] = 48'h1555_0555_403C;
    repeat (16) @(posedge ref_clk_i);
    #1;
    check_outputs(`CFG_RESET_VALUE);
    check(reg_rdata_o, 16'h0000);
    @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    @(posedge ref_clk_i);
    #1;
    check(scan_row_o, 5'h00);
    check_reg(`CFG_RESET_VALUE);
    $display("reset values test done");
    for (int r = 0; r < 4; r++)
    begin
      wr(`CFG_WORD_LO_ADDR, rows[r][15:0]);
      wr(`CFG_WORD_MID_ADDR, rows[r][31:16]);
      wr(`CFG_WORD_HI_ADDR, rows[r][47:32]);
      e = expect_rows[r];
      check_reg(e);
      check_outputs(e);
      check_scan(e[14]);
      $display("row %0d test done", r);
    end
    // Address 3 holds nothing: writes vanish and reads give zero.
    wr(2'h3, 16'hFFFF);
    rd(2'h3, d);
    check(d, 16'h0000);
    check_reg(e);
    // The last read returned a nonzero word, so a held value would show here.
    @(posedge ref_clk_i);
    #1;
    check(reg_rdata_o, 16'h0000);
    $display("unmapped address test done");
    // A second reset in mid-run must restore every field.
    @(posedge ref_clk_i);
    rst_n_i <= 1'h0;
    @(posedge ref_clk_i);
    #1;
    check_outputs(`CFG_RESET_VALUE);
    check(scan_row_o, 5'h00);
    check(reg_rdata_o, 16'h0000);
    @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    check_reg(`CFG_RESET_VALUE);
    $display("second reset test done");
    conclude();
  end
endmodule : test_output_channel_configuration
